/* File: bench/wdg_host_model.sv */
// Host software model: a bus master with access and refresh tasks.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/10ps
module wdg_host_model (
  input  wire logic                       mclk_i,
  input  wire logic                       waitrequest_i,
  input  wire logic [wdg_pkg::DATA_W-1:0] readdata_i,
  output wdg_pkg::wdg_avs_req_s           req_o
);
  // Idle bus from time zero
  initial req_o = '0;
  ////////////////////////////////////////////////////////////////////////
  // One access: hold until waitrequest is seen low, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    req_o.read <= ~wr;
    req_o.write <= wr;
    req_o.address <= a;
    req_o.writedata <= d;
    req_o.byteenable <= 4'hF;
    @(posedge mclk_i);
    while (waitrequest_i !== 1'b0) @(posedge mclk_i);
    q = readdata_i;
    req_o <= '0;
    @(posedge mclk_i);
  endtask
  // Refresh write carrying a key; software's periodic duty
  task automatic kick(input logic [7:0] key);
    logic [31:0] q;
    xfer(1'b1, wdg_pkg::OFF_REFRESH, {24'h0, key}, q);
  endtask
endmodule

/* File: bench/wdg_windowed_properties.sv */
// Port checker for the windowed watchdog, bound to its top module.
// Assumes a bus master that holds each request until waitrequest is low.
`timescale 1ns/10ps
module wdg_windowed_properties #(
  parameter int CNT_W = 16
) (
  input wire logic                        mclk_i,
  input wire logic                        rst_n_i,
  input wire logic                        por_n_i,
  input wire logic [31:0]                 reset_option_word_i,
  input wire wdg_pkg::wdg_avs_req_s       avs_req_i,
  input wire logic [wdg_pkg::DATA_W-1:0]  avs_readdata_o,
  input wire logic                        avs_waitrequest_o,
  input wire logic                        sys_reset_req_o,
  input wire logic                        nmi_o,
  input wire logic                        irq_o
);
  logic req;
  logic rd_ack;
  logic wr_ack;
  // Bus phase decode
  assign req    = avs_req_i.read | avs_req_i.write;
  assign rd_ack = avs_req_i.read & ~avs_waitrequest_o;
  assign wr_ack = avs_req_i.write & ~avs_waitrequest_o;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  // Bus timing and read data
  AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("Request answered without a wait state");
  AST_ONE_WAIT: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("Request not answered after one wait state");
  AST_RD_HOLD: assert property (rd_ack |=> $stable(avs_readdata_o)[*2])
    else $error("Read data changed after the answer");
  AST_UNMAPPED: assert property (rd_ack && avs_req_i.address >= 8'h20 |->
    avs_readdata_o == 32'h0) else $error("Unmapped read not zero");
  AST_OPT_READ: assert property (rd_ack && avs_req_i.address == wdg_pkg::OFF_OPTION |->
    avs_readdata_o == reset_option_word_i) else $error("Option read differs");
  // Error actions
  AST_SYS_HOLD: assert property (sys_reset_req_o |=> sys_reset_req_o)
    else $error("Reset request dropped before reset");
  AST_SYS_ACT: assert property ($rose(sys_reset_req_o) |-> !reset_option_word_i[1])
    else $error("Reset request in interrupt mode");
  AST_NMI_ACT: assert property ($rose(nmi_o) |-> reset_option_word_i[1] && !sys_reset_req_o)
    else $error("Interrupt raised in reset mode");
  AST_NMI_STICKY: assert property (nmi_o && !(wr_ack &&
    avs_req_i.address == wdg_pkg::OFF_NMI_STAT) |=> nmi_o) else $error("Interrupt flag lost");
  AST_IRQ_MASKED: assert property (wr_ack && avs_req_i.address == wdg_pkg::OFF_IRQ_MASK &&
    avs_req_i.byteenable[0] && avs_req_i.writedata[2:0] == 3'h0 |=> !irq_o)
    else $error("Interrupt high with all masked");
  // Main scenarios reached
  COV_NMI: cover property ($rose(nmi_o));
  COV_SYS: cover property ($rose(sys_reset_req_o));
  COV_IRQ: cover property ($rose(irq_o));
endmodule

bind wdg_windowed wdg_windowed_properties #(.CNT_W(CNT_W)) i_wdg_windowed_properties (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
  .reset_option_word_i(reset_option_word_i), .avs_req_i(avs_req_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sys_reset_req_o(sys_reset_req_o), .nmi_o(nmi_o), .irq_o(irq_o));

/* File: bench/wdg_windowed_tb_top.sv */
// Self-checking bench for the windowed watchdog.
// Assumes the host model drives the bus and the checker is bound.
`timescale 1ns/10ps
module wdg_windowed_tb_top;
  logic                  mclk;
  logic                  rst_n;
  logic                  por_n;
  logic [31:0]           opt;
  wdg_pkg::wdg_avs_req_s req;
  logic [31:0]           rdata;
  logic                  waitreq;
  logic                  sysrst;
  logic                  nmi;
  logic                  irq;
  int                    n_fail = 0;
  int                    checked = 0;
  // Design with a short count tick so a full timeout fits in the run, and host
  wdg_windowed #(.TICK_CYC(4)) i_wdg_windowed (.mclk_i(mclk), .rst_n_i(rst_n),
    .por_n_i(por_n), .reset_option_word_i(opt), .avs_req_i(req), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .sys_reset_req_o(sysrst), .nmi_o(nmi), .irq_o(irq));
  wdg_host_model i_wdg_host_model (.mclk_i(mclk), .waitrequest_i(waitreq),
    .readdata_i(rdata), .req_o(req));
  ////////////////////////////////////////////////////////////////////////
  // Clock at 250 MHz
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_wdg_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_wdg_host_model.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Reset for 16 cycles with a new option word; cold also clears the cause
  task automatic boot(input logic [31:0] o, input logic cold);
    rst_n <= 1'b0;
    por_n <= ~cold;
    opt <= o;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic st();
    repeat (3) @(posedge mclk);
  endtask
  // Watchdog on the run
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    close_out();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    opt = 32'h0;
    @(posedge mclk);
    boot(32'h2, 1'b1);
    rdchk(wdg_pkg::OFF_OPTION, 32'h2);
    rdchk(wdg_pkg::OFF_IRQ_MASK, 32'h0);
    rdchk(8'h20, 32'h0);
    rdchk(wdg_pkg::OFF_CAUSE, 32'h0);
    rdchk(wdg_pkg::OFF_CTRL, 32'h0);
    i_wdg_host_model.kick(8'hA5);
    rdchk(wdg_pkg::OFF_IRQ_STAT, 32'h0);
    wr(wdg_pkg::OFF_CTRL, 32'h1);
    rdchk(wdg_pkg::OFF_CTRL, 32'h1);
    repeat (2) @(posedge mclk);
    rdchk(wdg_pkg::OFF_COUNT, 32'h3FE);
    i_wdg_host_model.kick(8'hA5);
    rdchk(wdg_pkg::OFF_COUNT, 32'h3FF);
    rdchk(wdg_pkg::OFF_IRQ_STAT, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wr(wdg_pkg::OFF_IRQ_MASK, 32'h7);
    st();
    chk({31'h0, irq}, 32'h1);
    wr(wdg_pkg::OFF_IRQ_STAT, 32'h4);
    st();
    chk({31'h0, irq}, 32'h0);
    // Wrong key in interrupt mode
    i_wdg_host_model.kick(8'h5A);
    st();
    chk({31'h0, nmi}, 32'h1);
    chk({31'h0, sysrst}, 32'h0);
    rdchk(wdg_pkg::OFF_NMI_STAT, 32'h1);
    rdchk(wdg_pkg::OFF_CAUSE, 32'h2);
    rdchk(wdg_pkg::OFF_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rdchk(wdg_pkg::OFF_CTRL, 32'h1);
    wr(wdg_pkg::OFF_NMI_STAT, 32'h1);
    st();
    chk({31'h0, nmi}, 32'h0);
    wr(wdg_pkg::OFF_IRQ_MASK, 32'h0);
    st();
    chk({31'h0, irq}, 32'h0);
    // Silent host in interrupt mode: the counter runs out after 1024 ticks
    wr(wdg_pkg::OFF_CAUSE, 32'h3);
    repeat (4200) @(posedge mclk);
    chk({31'h0, nmi}, 32'h1);
    chk({31'h0, sysrst}, 32'h0);
    rdchk(wdg_pkg::OFF_CAUSE, 32'h1);
    rdchk(wdg_pkg::OFF_IRQ_STAT, 32'h3);
    // Reset mode, auto start, narrow window: early refresh is an error
    boot(32'h31, 1'b0);
    rdchk(wdg_pkg::OFF_CAUSE, 32'h1);
    wr(wdg_pkg::OFF_CAUSE, 32'h3);
    rdchk(wdg_pkg::OFF_CAUSE, 32'h0);
    rdchk(wdg_pkg::OFF_CTRL, 32'h1);
    i_wdg_host_model.kick(8'hA5);
    st();
    chk({31'h0, sysrst}, 32'h1);
    chk({31'h0, nmi}, 32'h0);
    rdchk(wdg_pkg::OFF_CAUSE, 32'h2);
    // Cause survives the system reset
    boot(32'hE, 1'b0);
    chk({31'h0, sysrst}, 32'h0);
    rdchk(wdg_pkg::OFF_COUNT, 32'h3FFF);
    rdchk(wdg_pkg::OFF_CAUSE, 32'h2);
    close_out();
  end
endmodule

/* File: verilog/wdg_pkg.sv */
// Shared constants and types for the windowed watchdog.
// Assumes a 250 MHz system clock and an Avalon-MM slave port with byte addresses.
package wdg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_REFRESH   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OPTION    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CAUSE     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_NMI_STAT  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h1C;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CAUSE_W        = 2;    // [0] timeout, [1] bad refresh
  localparam int CAUSE_TMO_BIT  = 0;
  localparam int CAUSE_BAD_BIT  = 1;
  localparam int NMI_W          = 1;    // [0] watchdog NMI source flag
  localparam int IRQ_W          = 3;    // [0] timeout, [1] bad refresh, [2] good refresh
  localparam int IRQ_TMO_BIT    = 0;
  localparam int IRQ_BAD_BIT    = 1;
  localparam int IRQ_OK_BIT     = 2;

  // Refresh key in the low byte of a refresh write
  localparam logic [7:0] REFRESH_KEY = 8'hA5;

  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Count timing
  localparam int CLK_MHZ  = 250;
  localparam int TICK_NS  = 1000;                                   // Count tick period
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;             // Cycles per tick
  localparam int TICK_W   = $clog2(TICK_CYC);

  // Counter top values selected by the option word
  localparam logic [15:0] TOP_SEL0 = 16'h03FF;
  localparam logic [15:0] TOP_SEL1 = 16'h0FFF;
  localparam logic [15:0] TOP_SEL2 = 16'h1FFF;
  localparam logic [15:0] TOP_SEL3 = 16'h3FFF;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic {
    ACT_RESET,
    ACT_NMI
  } wdg_action_e;

  // Option word layout, MSB first
  typedef struct packed {
    logic [23:0] rsvd;
    logic [1:0]  win_end;     // Window lower bound, in quarters of top
    logic [1:0]  win_start;   // Window upper bound, top minus quarters
    logic [1:0]  period;      // Counter top select
    wdg_action_e action;      // Error action
    logic        auto_start;  // Start counting on reset release
  } wdg_opt_s;

  // Avalon-MM request from the master
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } wdg_avs_req_s;

endpackage

/* File: verilog/wdg_sticky.sv */
// Sticky flag bank, set by hardware events and cleared by writing ones.
// Assumes set and clear arrive as single-cycle vectors in the same clock.
`timescale 1ns/10ps
module wdg_sticky #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flag_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= '0;
    end else begin
      flag_o <= (flag_o & ~clr_i) | set_i;
    end
  end

endmodule

/* File: verilog/wdg_windowed.sv */
// Windowed watchdog with reset or NMI error action and reset-cause record.
// Assumes an Avalon-MM master, a system reset and a separate power-on reset.
//
// How it works
// - A counter that runs out before a refresh flags a watchdog error.
// - Refresh counts only inside the window; early or late refresh is an error.
// - Each error either requests a system reset or raises the NMI.
// - Window, period and action come only from the option word; start comes from it or from a control register write.
// - The option word is captured when reset releases and then frozen.
// - In NMI mode an error sets the watchdog NMI source flag.
// - A reset-cause record survives system reset and is readable by software.
// - The cause record is set for both timeout and bad refresh.
`timescale 1ns/10ps
module wdg_windowed #(
  parameter int CNT_W    = 16,
  parameter int TICK_CYC = wdg_pkg::TICK_CYC  // Clock cycles per count tick
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      por_n_i,
  input  wire logic [31:0]               reset_option_word_i,
  input  wire wdg_pkg::wdg_avs_req_s     avs_req_i,
  output logic      [wdg_pkg::DATA_W-1:0] avs_readdata_o,
  output logic                           avs_waitrequest_o,
  output logic                           sys_reset_req_o,
  output logic                           nmi_o,
  output logic                           irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Local constants; the prescaler is kept at least one bit wide
  localparam int                TICK_W    = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);  // Final prescaler state

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  wdg_pkg::wdg_opt_s                opt_r;
  logic                             opt_loaded_r;
  logic                             running_r;
  logic                             halted_r;
  logic [CNT_W-1:0]                 count_r;
  logic [TICK_W-1:0]                tick_cnt_r;
  logic                             ack_r;
  logic [wdg_pkg::DATA_W-1:0]       rdata_r;
  logic [wdg_pkg::IRQ_W-1:0]        irq_mask_r;
  logic [wdg_pkg::CAUSE_W-1:0]      cause_q;
  logic [wdg_pkg::NMI_W-1:0]        nmi_q;
  logic [wdg_pkg::IRQ_W-1:0]        irq_q;
  logic [CNT_W-1:0]                 top_val;
  logic [CNT_W-1:0]                 quarter;
  logic [CNT_W-1:0]                 win_hi;
  logic [CNT_W-1:0]                 win_lo;
  logic                             in_window;
  logic                             req_any;
  logic                             wr_acc;
  logic                             wr_lo;
  logic                             tick;
  logic                             start_req;
  logic                             refresh_wr;
  logic                             refresh_ok;
  logic                             refresh_bad;
  logic                             timeout;
  logic                             wdg_err;
  logic [wdg_pkg::DATA_W-1:0]       wmask;
  logic [wdg_pkg::DATA_W-1:0]       w1c;
  logic [wdg_pkg::CAUSE_W-1:0]      cause_set;
  logic [wdg_pkg::CAUSE_W-1:0]      cause_clr;
  logic [wdg_pkg::NMI_W-1:0]        nmi_set;
  logic [wdg_pkg::NMI_W-1:0]        nmi_clr;
  logic [wdg_pkg::IRQ_W-1:0]        irq_set;
  logic [wdg_pkg::IRQ_W-1:0]        irq_clr;
  logic [wdg_pkg::DATA_W-1:0]       rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave handshake: one wait state per access
  // The wait state gives the read mux a full cycle into rdata_r
  assign req_any           = avs_req_i.read | avs_req_i.write;
  assign avs_waitrequest_o = req_any & ~ack_r;
  assign wr_acc            = avs_req_i.write & ack_r;
  assign wr_lo             = wr_acc & avs_req_i.byteenable[0];
  assign avs_readdata_o    = rdata_r;

  // Acknowledge toggles high for the cycle after a request appears
  // A held request therefore sees waitrequest fall on every second edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req_any & ~ack_r;
    end
  end

  // Byte lane mask for write-one-to-clear fields
  // Lanes with byteenable low never clear a flag
  always_comb begin
    for (int i = 0; i < wdg_pkg::BE_W; i++) begin
      wmask[i*8 +: 8] = {8{avs_req_i.byteenable[i]}};
    end
    w1c = (wr_acc ? avs_req_i.writedata : '0) & wmask;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Option word capture on the first clock after reset release
  // Later changes on the option pins wait for the next system reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt_r        <= '0;
      opt_loaded_r <= 1'b0;
    end else if (!opt_loaded_r) begin
      opt_r        <= wdg_pkg::wdg_opt_s'(reset_option_word_i);
      opt_loaded_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Period and window derived from the captured option word
  // Nothing written at run time can alter these values
  always_comb begin
    case (opt_r.period)
      2'h0:    top_val = CNT_W'(wdg_pkg::TOP_SEL0);
      2'h1:    top_val = CNT_W'(wdg_pkg::TOP_SEL1);
      2'h2:    top_val = CNT_W'(wdg_pkg::TOP_SEL2);
      2'h3:    top_val = CNT_W'(wdg_pkg::TOP_SEL3);
      default: top_val = CNT_W'(wdg_pkg::TOP_SEL0);
    endcase
  end

  // Window spans win_lo..win_hi of the down-counting value
  // Above win_hi a refresh is early, below win_lo it is late
  assign quarter   = top_val >> 2;
  assign win_hi    = CNT_W'(top_val - CNT_W'(quarter * opt_r.win_start));
  assign win_lo    = CNT_W'(quarter * opt_r.win_end);
  assign in_window = (count_r <= win_hi) && (count_r >= win_lo);

  ////////////////////////////////////////////////////////////////////////////////
  // Event decode
  // Refreshes are ignored before the start and after a reset request
  // A good refresh on the timeout tick wins over the timeout
  assign start_req   = wr_lo && (avs_req_i.address == wdg_pkg::OFF_CTRL)
                       && avs_req_i.writedata[wdg_pkg::CTRL_START_BIT];
  assign refresh_wr  = wr_lo && (avs_req_i.address == wdg_pkg::OFF_REFRESH);
  assign refresh_ok  = refresh_wr && running_r && !halted_r && in_window
                       && (avs_req_i.writedata[7:0] == wdg_pkg::REFRESH_KEY);
  assign refresh_bad = refresh_wr && running_r && !halted_r && !refresh_ok;
  assign tick        = running_r && !halted_r
                       && (tick_cnt_r == TICK_LAST);
  assign timeout     = tick && (count_r == '0) && !refresh_ok;
  assign wdg_err     = timeout | refresh_bad;

  ////////////////////////////////////////////////////////////////////////////////
  // Run state: started by option or software, never stopped except by reset
  // Software cannot stop it, so a runaway program cannot disarm it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running_r <= 1'b0;
    end else if (!opt_loaded_r) begin
      running_r <= 1'b0;
    end else if (!running_r && (opt_r.auto_start || start_req)) begin
      running_r <= 1'b1;
    end
  end

  // Tick prescaler, restarted with each good refresh so a refresh gives a full period
  // This keeps the window edges exact relative to the last good refresh
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_r <= '0;
    end else if (!running_r || refresh_ok || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // Down counter
  // Priority: reload by refresh, reload by NMI-mode error, then count
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= '0;
    end else if (!running_r) begin
      count_r <= top_val;
    end else if (refresh_ok) begin
      count_r <= top_val;
    end else if (wdg_err && (opt_r.action == wdg_pkg::ACT_NMI)) begin
      count_r <= top_val;  // NMI mode keeps watching after an error
    end else if (tick) begin
      count_r <= count_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Error action: reset request holds until the system reset arrives
  // Counting stops so no second error can follow the first
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halted_r <= 1'b0;
    end else if (wdg_err && (opt_r.action == wdg_pkg::ACT_RESET)) begin
      halted_r <= 1'b1;
    end
  end

  assign sys_reset_req_o = halted_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky flags
  // Every flag is cleared by writing a one; a set in the same cycle wins
  always_comb begin
    cause_set                         = '0;
    cause_set[wdg_pkg::CAUSE_TMO_BIT] = timeout;
    cause_set[wdg_pkg::CAUSE_BAD_BIT] = refresh_bad;
    cause_clr = (avs_req_i.address == wdg_pkg::OFF_CAUSE)
                ? w1c[wdg_pkg::CAUSE_W-1:0] : '0;
    nmi_set   = {wdg_pkg::NMI_W{wdg_err && (opt_r.action == wdg_pkg::ACT_NMI)}};
    nmi_clr   = (avs_req_i.address == wdg_pkg::OFF_NMI_STAT)
                ? w1c[wdg_pkg::NMI_W-1:0] : '0;
    irq_set                       = '0;
    irq_set[wdg_pkg::IRQ_TMO_BIT] = timeout;
    irq_set[wdg_pkg::IRQ_BAD_BIT] = refresh_bad;
    irq_set[wdg_pkg::IRQ_OK_BIT]  = refresh_ok;
    irq_clr   = (avs_req_i.address == wdg_pkg::OFF_IRQ_STAT)
                ? w1c[wdg_pkg::IRQ_W-1:0] : '0;
  end

  // Reset cause lives on the power-on reset so it outlasts a watchdog reset
  // Clearing it is left to software once the cause has been read
  wdg_sticky #(
    .W (wdg_pkg::CAUSE_W)
  ) u_cause (
    .clk_i   (mclk_i),
    .rst_n_i (por_n_i),
    .set_i   (cause_set),
    .clr_i   (cause_clr),
    .flag_o  (cause_q)
  );

  // Watchdog NMI source flag
  // Only an error in NMI mode sets it
  wdg_sticky #(
    .W (wdg_pkg::NMI_W)
  ) u_nmi (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .set_i   (nmi_set),
    .clr_i   (nmi_clr),
    .flag_o  (nmi_q)
  );

  // Maskable event status
  // Timeout, bad refresh and good refresh, each with its own mask bit
  wdg_sticky #(
    .W (wdg_pkg::IRQ_W)
  ) u_irq (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .set_i   (irq_set),
    .clr_i   (irq_clr),
    .flag_o  (irq_q)
  );

  // Level outputs from the flag registers, the IRQ gated by its mask
  assign nmi_o = |nmi_q;
  assign irq_o = |(irq_q & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt mask register
  // All events are masked after reset until software opts in
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= wdg_pkg::IRQ_MASK_RST;
    end else if (wr_lo && (avs_req_i.address == wdg_pkg::OFF_IRQ_MASK)) begin
      irq_mask_r <= avs_req_i.writedata[wdg_pkg::IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped and write-only offsets read as zero
  // Decoded from the live address and captured in the wait cycle
  always_comb begin
    rdata_nxt = '0;
    case (avs_req_i.address)
      wdg_pkg::OFF_CTRL:     rdata_nxt[wdg_pkg::CTRL_START_BIT] = running_r;
      wdg_pkg::OFF_COUNT:    rdata_nxt[CNT_W-1:0] = count_r;
      wdg_pkg::OFF_OPTION:   rdata_nxt = opt_r;
      wdg_pkg::OFF_CAUSE:    rdata_nxt[wdg_pkg::CAUSE_W-1:0] = cause_q;
      wdg_pkg::OFF_NMI_STAT: rdata_nxt[wdg_pkg::NMI_W-1:0] = nmi_q;
      wdg_pkg::OFF_IRQ_STAT: rdata_nxt[wdg_pkg::IRQ_W-1:0] = irq_q;
      wdg_pkg::OFF_IRQ_MASK: rdata_nxt[wdg_pkg::IRQ_W-1:0] = irq_mask_r;
      default:               rdata_nxt = '0;
    endcase
  end

  // Read data captured in the wait cycle, standing at the acknowledge edge
  // Held until the next read so a slow master still sees it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (avs_req_i.read && !ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

endmodule
